// ---- tmdc_top.sv ----
// Purpose: mode selection, driver control and fault reporting
// Assumes: pins come from outside the clock domain; link clock is sampled
// Notes: driver outputs are level plus output enable, enable low drives
`timescale 1ns/1ps
module tmdc_top (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic interface_style_select,
    input wire logic uart_port_select,
    input wire logic chip_select_or_pushpull,
    input wire logic serial_in_tx_lowside,
    input wire logic clock_or_enable_limit_pin,
    input wire logic line_transmit_in,
    input wire logic line_drive_enable,
    input wire logic aux_drive_input,
    input wire logic aux_sense_input,
    input wire logic line_level_in,
    input wire logic line_oc_in,
    input wire logic aux_oc_in,
    input wire logic mux_submode_bit,
    input wire logic line_drv_disable,
    input wire logic line_drv_state_bit,
    input wire logic aux_drv_disable,
    input wire logic aux_drv_state_bit,
    input wire logic aux_tracks_line,
    input wire logic receiver_disable,
    input wire logic autoretry_en,
    input wire logic [1:0] limit_sel_field,
    input wire logic [1:0] line_style_sel,
    input wire logic [1:0] aux_style_sel,
    input wire logic [15:0] blank_cyc_cfg,
    input wire logic interrupt_flag_read,
    output logic line_drv_level,
    output logic line_drv_oe_n,
    output logic [1:0] line_drv_style,
    output logic aux_drv_level,
    output logic aux_drv_oe_n,
    output logic [1:0] aux_drv_style,
    output logic [1:0] drv_limit_sel,
    output logic line_receive_out,
    output logic line_receive_oe_n,
    output logic shared_serial_output,
    output logic shared_serial_oe_n,
    output logic aux_sense_output,
    output logic irq_overcurrent_n,
    output logic line_fault_status,
    output logic line_fault_irq_flag,
    output logic aux_fault_status,
    output logic aux_fault_irq_flag,
    output logic line_level_status,
    output logic line_level_valid,
    output logic rx_deglitch_en,
    output logic weak_pull_en,
    output logic spi_port_active,
    output logic uart_on_shared
);
    localparam int NS = 11;

    typedef struct packed {
        logic [NS-1:0] s1;
        logic [NS-1:0] s2;
        logic sel_d;
        logic samp_en;
        logic samp_tx;
        logic ldl;
        logic ldoe_n;
        logic [1:0] lsty;
        logic adl;
        logic adoe_n;
        logic [1:0] asty;
        logic [1:0] lim;
        logic rxo;
        logic rxoe_n;
        logic sso;
        logic ssoe_n;
        logic auxo;
        logic irq_n;
        logic lfs;
        logic lfi;
        logic afs;
        logic afi;
        logic lvl;
        logic lvlv;
        logic dgl;
        logic wpe;
        logic spi_act;
        logic uart_sh;
    } tmdc_st_t;
    tmdc_st_t s_reg, s_next;

    logic [1:0] rst_sync_reg;
    logic rst_n;
    logic [NS-1:0] pins;
    logic i_ser, i_usel, i_cs, i_sdi, i_clk, i_tx, i_en, i_lo;
    logic i_di, i_cq, i_loc, i_aoc;
    logic l_fault, a_fault, l_roff, a_roff;
    logic [15:0] blank;
    logic retry;

    // Reset released through two flops
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    assign pins = {interface_style_select, uart_port_select,
                   chip_select_or_pushpull, serial_in_tx_lowside,
                   clock_or_enable_limit_pin, line_transmit_in,
                   line_drive_enable, aux_drive_input, aux_sense_input,
                   line_level_in, line_oc_in};
    // Only the second stage is read
    assign {i_ser, i_usel, i_cs, i_sdi, i_clk, i_tx, i_en, i_lo, i_di, i_cq,
            i_loc} = s_reg.s2;
    assign i_aoc = aux_oc_in;

    assign blank = i_ser ? blank_cyc_cfg :
                   16'(tmdc_pkg::PIN_BLANK_CYC);
    assign retry = i_ser & autoretry_en;

    tmdc_fault u_line_flt (
        .clk(core_clk),
        .rst_n(rst_n),
        .oc(i_loc),
        .blank_cyc(blank),
        .autoretry(retry),
        .fault(l_fault),
        .retry_off(l_roff)
    );
    tmdc_fault u_aux_flt (
        .clk(core_clk),
        .rst_n(rst_n),
        .oc(i_aoc),
        .blank_cyc(blank),
        .autoretry(retry),
        .fault(a_fault),
        .retry_off(a_roff)
    );

    always_comb begin
        logic mux, uart_sh, en_src, tx_src, l_on, l_lvl, a_on, a_lvl;
        logic fall;
        s_next = s_reg;
        mux = 1'b0;
        uart_sh = 1'b0;
        en_src = 1'b0;
        tx_src = 1'b0;
        l_on = 1'b0;
        l_lvl = 1'b0;
        a_on = 1'b0;
        a_lvl = 1'b0;
        fall = 1'b0;
        s_next.s1 = pins;
        s_next.s2 = s_reg.s1;
        s_next.sel_d = i_usel;
        fall = s_reg.sel_d & ~i_usel;
        if (fall) begin
            s_next.samp_en = i_clk;
            s_next.samp_tx = i_sdi;
        end
        if (!i_ser) begin
            // Pin control: fixed settings
            s_next.dgl = 1'b1;
            s_next.wpe = 1'b0;
            s_next.spi_act = 1'b0;
            s_next.uart_sh = 1'b0;
            s_next.lsty = i_cs ? tmdc_pkg::TMDC_PUSHPULL :
                          (i_sdi ? tmdc_pkg::TMDC_LOWSIDE :
                           tmdc_pkg::TMDC_HIGHSIDE);
            s_next.asty = s_next.lsty;
            s_next.lim = i_clk ? tmdc_pkg::LIM_200MA :
                         tmdc_pkg::LIM_100MA;
            l_on = i_en;
            l_lvl = ~i_tx;
            a_on = 1'b1;
            a_lvl = ~i_lo;
            s_next.rxo = ~i_cq;
            s_next.rxoe_n = 1'b0;
            s_next.sso = 1'b1;
            s_next.ssoe_n = 1'b1;
            s_next.auxo = ~i_di;
            s_next.lvlv = 1'b1;
            s_next.irq_n = ~(l_fault | a_fault);
            s_next.lfi = 1'b0;
            s_next.afi = 1'b0;
        end else begin
            s_next.dgl = 1'b1;
            s_next.wpe = 1'b0;
            s_next.lsty = line_style_sel;
            s_next.asty = aux_style_sel;
            s_next.lim = limit_sel_field;
            // Parallel mode uses dedicated pins; mux routes shared ones
            mux = i_usel | mux_submode_bit;
            if (!mux) begin
                en_src = i_en;
                tx_src = i_tx;
                s_next.spi_act = 1'b1;
            end else if (!mux_submode_bit) begin
                uart_sh = i_cs;
                en_src = i_clk;
                tx_src = i_sdi;
                s_next.spi_act = ~i_cs;
            end else begin
                uart_sh = i_usel;
                en_src = s_reg.samp_en;
                tx_src = s_reg.samp_tx;
                s_next.spi_act = ~i_usel;
            end
            s_next.uart_sh = uart_sh;
            // UART drives via enable/tx; state bit forces the driven level
            l_on = ~line_drv_disable & (line_drv_state_bit | en_src);
            l_lvl = line_drv_state_bit ? 1'b1 : ~tx_src;
            if (aux_tracks_line) begin
                a_on = ~aux_drv_disable & l_on;
                a_lvl = l_lvl;
            end else begin
                a_on = ~aux_drv_disable;
                a_lvl = aux_drv_state_bit ? 1'b1 : ~i_lo;
            end
            s_next.rxo = ~i_cq;
            s_next.rxoe_n = receiver_disable;
            s_next.lvlv = ~receiver_disable;
            s_next.auxo = ~i_di;
            s_next.sso = ~i_cq;
            s_next.ssoe_n = ~mux | (i_cs & receiver_disable);
            // Set wins over the read clear
            s_next.lfi = l_fault | (s_reg.lfi & ~interrupt_flag_read);
            s_next.afi = a_fault | (s_reg.afi & ~interrupt_flag_read);
            s_next.irq_n = ~(s_next.lfi | s_next.afi);
        end
        s_next.lfs = l_fault;
        s_next.afs = a_fault;
        s_next.lvl = i_cq;
        s_next.ldl = l_lvl;
        s_next.ldoe_n = ~(l_on & ~l_roff);
        s_next.adl = a_lvl;
        s_next.adoe_n = ~(a_on & ~a_roff);
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '0;
            s_reg.ldoe_n <= 1'b1;
            s_reg.adoe_n <= 1'b1;
            s_reg.rxoe_n <= 1'b1;
            s_reg.ssoe_n <= 1'b1;
            s_reg.irq_n <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign line_drv_level = s_reg.ldl;
    assign line_drv_oe_n = s_reg.ldoe_n;
    assign line_drv_style = s_reg.lsty;
    assign aux_drv_level = s_reg.adl;
    assign aux_drv_oe_n = s_reg.adoe_n;
    assign aux_drv_style = s_reg.asty;
    assign drv_limit_sel = s_reg.lim;
    assign line_receive_out = s_reg.rxo;
    assign line_receive_oe_n = s_reg.rxoe_n;
    assign shared_serial_output = s_reg.sso;
    assign shared_serial_oe_n = s_reg.ssoe_n;
    assign aux_sense_output = s_reg.auxo;
    assign irq_overcurrent_n = s_reg.irq_n;
    assign line_fault_status = s_reg.lfs;
    assign line_fault_irq_flag = s_reg.lfi;
    assign aux_fault_status = s_reg.afs;
    assign aux_fault_irq_flag = s_reg.afi;
    assign line_level_status = s_reg.lvl;
    assign line_level_valid = s_reg.lvlv;
    assign rx_deglitch_en = s_reg.dgl;
    assign weak_pull_en = s_reg.wpe;
    assign spi_port_active = s_reg.spi_act;
    assign uart_on_shared = s_reg.uart_sh;

    property p_pin_irq;
        @(posedge core_clk) disable iff (!rst_n)
        (!i_ser && (l_fault || a_fault)) |=> !irq_overcurrent_n;
    endproperty
    a_pin_irq: assert property (p_pin_irq) else $error("pin irq");
    property p_latch;
        @(posedge core_clk) disable iff (!rst_n)
        (i_ser && line_fault_irq_flag && !interrupt_flag_read && $stable(i_ser))
        |=> line_fault_irq_flag;
    endproperty
    a_latch: assert property (p_latch) else $error("flag lost");
    property p_pin_aux;
        @(posedge core_clk) disable iff (!rst_n)
        (!i_ser && !a_roff) |=> (!aux_drv_oe_n && aux_drv_level == !$past(i_lo));
    endproperty
    a_pin_aux: assert property (p_pin_aux) else $error("aux pin");
    property p_pin_line;
        @(posedge core_clk) disable iff (!rst_n)
        (!i_ser && !l_roff) |=> (line_drv_oe_n == !$past(i_en));
    endproperty
    a_pin_line: assert property (p_pin_line) else $error("line en");
    property p_lim;
        @(posedge core_clk) disable iff (!rst_n)
        (!i_ser && i_clk) |=> drv_limit_sel == tmdc_pkg::LIM_200MA;
    endproperty
    a_lim: assert property (p_lim) else $error("limit");
    property p_dis;
        @(posedge core_clk) disable iff (!rst_n)
        (i_ser && line_drv_disable) |=> line_drv_oe_n;
    endproperty
    a_dis: assert property (p_dis) else $error("disable");
    property p_rx;
        @(posedge core_clk) disable iff (!rst_n)
        !i_ser |=> (!line_receive_oe_n && line_level_valid);
    endproperty
    a_rx: assert property (p_rx) else $error("rx off");
    property p_rxdis;
        @(posedge core_clk) disable iff (!rst_n)
        (i_ser && receiver_disable) |=> (line_receive_oe_n && !line_level_valid);
    endproperty
    a_rxdis: assert property (p_rxdis) else $error("rx dis");
    // A serial fault must show in status, flag and line one cycle later
    sequence s_ser_lfault;
        i_ser && l_fault;
    endsequence
    sequence s_flag_irq;
        line_fault_irq_flag && !irq_overcurrent_n && line_fault_status;
    endsequence
    property p_ser_fault;
        @(posedge core_clk) disable iff (!rst_n)
        s_ser_lfault |=> s_flag_irq;
    endproperty
    a_ser_fault: assert property (p_ser_fault) else $error("flag");
endmodule

// ---- tmdc_pkg.sv ----
// Purpose: constants and types for the transceiver mode and driver control
// Assumes: 20 MHz core clock, no register bus, register bits are plain ports
// Notes: blanking and retry counts derive from times and the clock rate
package tmdc_pkg;
    localparam int CLK_HZ = 20000000;
    localparam int PIN_BLANK_US = 128;
    localparam int PIN_BLANK_CYC = PIN_BLANK_US * (CLK_HZ / 1000000);
    localparam int RETRY_OFF_US = 128;
    localparam int RETRY_OFF_CYC = RETRY_OFF_US * (CLK_HZ / 1000000);
    localparam int BLANK_W = 16;
    localparam logic [1:0] LIM_50MA = 2'h0;
    localparam logic [1:0] LIM_100MA = 2'h1;
    localparam logic [1:0] LIM_200MA = 2'h2;
    localparam logic [1:0] LIM_250MA = 2'h3;
    typedef enum logic [1:0] {
        TMDC_HIGHSIDE = 2'h0,
        TMDC_LOWSIDE = 2'h1,
        TMDC_PUSHPULL = 2'h2
    } tmdc_style_t;
    typedef enum logic [1:0] {
        TMDC_OK = 2'h0,
        TMDC_BLANK = 2'h1,
        TMDC_FAULT = 2'h2,
        TMDC_RETRY = 2'h3
    } tmdc_flt_t;
endpackage

// ---- tmdc_fault.sv ----
// Purpose: per-driver overcurrent blanking, fault state and autoretry
// Assumes: overcurrent input already synchronised
// Notes: retry off time equals the pin-mode blanking time
`timescale 1ns/1ps
module tmdc_fault (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic oc,
    input wire logic [15:0] blank_cyc,
    input wire logic autoretry,
    output logic fault,
    output logic retry_off
);
    typedef struct packed {
        tmdc_pkg::tmdc_flt_t st;
        logic [15:0] cnt;
    } tmdc_fs_t;
    tmdc_fs_t s_reg, s_next;

    always_comb begin
        s_next = s_reg;
        unique case (s_reg.st)
            tmdc_pkg::TMDC_OK: begin
                s_next.cnt = 16'h0;
                if (oc) begin
                    s_next.st = tmdc_pkg::TMDC_BLANK;
                end
            end
            tmdc_pkg::TMDC_BLANK: begin
                if (!oc) begin
                    s_next.st = tmdc_pkg::TMDC_OK;
                end else if (s_reg.cnt >= blank_cyc) begin
                    s_next.st = tmdc_pkg::TMDC_FAULT;
                    s_next.cnt = 16'h0;
                end else begin
                    s_next.cnt = s_reg.cnt + 16'h1;
                end
            end
            tmdc_pkg::TMDC_FAULT: begin
                s_next.cnt = 16'h0;
                if (!oc) begin
                    s_next.st = tmdc_pkg::TMDC_OK;
                end else if (autoretry) begin
                    s_next.st = tmdc_pkg::TMDC_RETRY;
                end
            end
            tmdc_pkg::TMDC_RETRY: begin
                if (s_reg.cnt >= 16'(tmdc_pkg::RETRY_OFF_CYC)) begin
                    s_next.st = tmdc_pkg::TMDC_OK;
                    s_next.cnt = 16'h0;
                end else begin
                    s_next.cnt = s_reg.cnt + 16'h1;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign fault = (s_reg.st == tmdc_pkg::TMDC_FAULT) ||
                   (s_reg.st == tmdc_pkg::TMDC_RETRY);
    assign retry_off = (s_reg.st == tmdc_pkg::TMDC_RETRY);

    property p_blank_min;
        @(posedge clk) disable iff (!rst_n)
        $rose(fault) |-> $past(oc, 2);
    endproperty
    a_blank_min: assert property (p_blank_min) else $error("fault no oc");
endmodule

// ---- tmdc_host_model.sv ----
// Purpose: host model that owns the UART pins and the link clock
// Assumes: each frame bit lasts two link clock periods
// Notes: link clock stands still outside frames; idle levels from the bench
`timescale 1ns/1ps
module tmdc_host_model (
    input wire logic start,
    input wire logic [7:0] frame_byte,
    input wire logic pin_en,
    input wire logic pin_tx,
    input wire logic pin_clk,
    output logic line_transmit_in,
    output logic line_drive_enable,
    output logic link_clk_pin,
    output logic mid,
    output logic busy
);
    logic lclk = 1'b0;
    logic busy_reg = 1'b0;
    logic mid_reg = 1'b0;
    logic tx_reg = 1'b1;
    logic [9:0] sh_reg = 10'h3FF;
    logic [3:0] n_reg = 4'h0;

    // Odd offset keeps the link clock off the core clock grid
    initial begin
        #7;
        forever begin
            #200;
            lclk = busy_reg ? ~lclk : 1'b0;
        end
    end

    always @(posedge start or negedge lclk) begin
        if (start && !busy_reg) begin
            busy_reg <= 1'b1;
            mid_reg <= 1'b0;
            n_reg <= 4'h0;
            tx_reg <= 1'b1;
            sh_reg <= {1'b1, frame_byte, 1'b0};
        end else if (busy_reg) begin
            if (!mid_reg) begin
                tx_reg <= sh_reg[0];
                sh_reg <= {1'b1, sh_reg[9:1]};
                n_reg <= n_reg + 4'h1;
            end else if (n_reg == 4'hA) begin
                busy_reg <= 1'b0;
            end
            mid_reg <= ~mid_reg;
        end
    end

    assign busy = busy_reg;
    assign mid = mid_reg;
    assign line_transmit_in = busy_reg ? tx_reg : pin_tx;
    assign line_drive_enable = busy_reg | pin_en;
    assign link_clk_pin = busy_reg ? lclk : pin_clk;
endmodule

// ---- tb_tmdc_top.sv ----
// Purpose: self-checking bench for the mode and driver control
// Assumes: host model owns the UART pins; the rest is driven here
// Notes: pin inputs need about three cycles to reach the outputs
`timescale 1ns/1ps
module tb_tmdc_top;
    typedef struct packed {
        logic [10:0] i;
        logic [6:0] e;
    } tmdc_row_t;
    logic clk = 1'b0, rstn = 1'b0, iss = 1'b0, ups = 1'b0, cspp = 1'b0;
    logic sdi = 1'b0, p_en = 1'b0, p_tx = 1'b1, p_aux = 1'b0, p_clk = 1'b0;
    logic lvl_in = 1'b0, dsense = 1'b0, loc = 1'b0, aoc = 1'b0, mux = 1'b0;
    logic ldis = 1'b0, lst = 1'b0, trk = 1'b0, rdis = 1'b0, retry = 1'b0;
    logic rd = 1'b0, start = 1'b0, adis = 1'b0, ast = 1'b0;
    logic [1:0] lsel = 2'h0, ssel = 2'h0, asel = 2'h0;
    logic lls;
    logic txi, ten, lim, mid, busy, l_lvl, l_oe, a_lvl, a_oe, rx_o, rx_oe;
    logic so, so_oe, as_o, irq_n, lf, lff, af, aff, llv, dg, wp, spi, ush;
    logic [1:0] l_sty, lim_sel, a_sty;
    tmdc_row_t rows [8];
    int err_count = 0;
    int num_checks = 0;
    int n;

    tmdc_host_model host (.start(start), .frame_byte(8'hA5), .pin_en(p_en),
        .pin_tx(p_tx), .pin_clk(p_clk), .line_transmit_in(txi),
        .line_drive_enable(ten), .link_clk_pin(lim), .mid(mid), .busy(busy));

    tmdc_top dut (.core_clk(clk), .rstn(rstn), .interface_style_select(iss),
        .uart_port_select(ups), .chip_select_or_pushpull(cspp),
        .serial_in_tx_lowside(sdi), .clock_or_enable_limit_pin(lim),
        .line_transmit_in(txi), .line_drive_enable(ten),
        .aux_drive_input(p_aux), .aux_sense_input(dsense),
        .line_level_in(lvl_in), .line_oc_in(loc), .aux_oc_in(aoc),
        .mux_submode_bit(mux), .line_drv_disable(ldis),
        .line_drv_state_bit(lst), .aux_drv_disable(adis),
        .aux_drv_state_bit(ast), .aux_tracks_line(trk),
        .receiver_disable(rdis), .autoretry_en(retry),
        .limit_sel_field(lsel), .line_style_sel(ssel),
        .aux_style_sel(asel), .blank_cyc_cfg(16'h0010),
        .interrupt_flag_read(rd), .line_drv_level(l_lvl),
        .line_drv_oe_n(l_oe), .line_drv_style(l_sty),
        .aux_drv_level(a_lvl), .aux_drv_oe_n(a_oe), .aux_drv_style(a_sty),
        .drv_limit_sel(lim_sel), .line_receive_out(rx_o),
        .line_receive_oe_n(rx_oe), .shared_serial_output(so),
        .shared_serial_oe_n(so_oe), .aux_sense_output(as_o),
        .irq_overcurrent_n(irq_n), .line_fault_status(lf),
        .line_fault_irq_flag(lff), .aux_fault_status(af),
        .aux_fault_irq_flag(aff), .line_level_status(lls),
        .line_level_valid(llv), .rx_deglitch_en(dg), .weak_pull_en(wp),
        .spi_port_active(spi), .uart_on_shared(ush));

    always #25 clk = ~clk;

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // Sample just after the edge so the design's updates have landed
    task automatic wt(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        #2000000;
        err_count++;
        report_and_stop();
    end

    initial begin
        // Row: style, cs, sdi, clk pin, en, tx, aux in, state, disable, sel
        rows = '{'{11'h040, 7'h23}, '{11'h1B0, 7'h4C}, '{11'h260, 7'h13},
            '{11'h3D0, 7'h34}, '{11'h450, 7'h20}, '{11'h421, 7'h4B},
            '{11'h47A, 7'h34}, '{11'h46F, 7'h57}};
        wt(9);
        chk({l_oe, a_oe, irq_n, lff}, 4'hE);
        @(posedge clk);
        rstn <= 1'b1;
        wt(4);
        $display("reset test done");
        for (int k = 0; k < 8; k++) begin
            @(posedge clk);
            {iss, cspp, sdi, p_clk, p_en, p_tx, p_aux, lst, ldis, lsel} <=
                rows[k].i;
            ssel <= {rows[k].i[1], rows[k].i[0] & ~rows[k].i[1]};
            lvl_in <= k[0];
            dsense <= !k[0];
            wt(6);
            chk(l_oe, rows[k].e[6]);
            if (!rows[k].e[6]) chk(l_lvl, rows[k].e[5]);
            chk(l_sty, rows[k].e[4:3]);
            chk(lim_sel, rows[k].e[2:1]);
            chk({a_oe, a_lvl}, {1'b0, rows[k].e[0]});
            chk({rx_o, rx_oe, lls}, {!k[0], 1'b0, k[0]});
            chk(as_o, k[0]);
            if (!rows[k].i[10]) chk({dg, wp}, 2'h2);
        end
        $display("row tests done");
        // Serial mode from the last row: the auxiliary bits are exercised here
        @(posedge clk);
        adis <= 1'b1;
        asel <= 2'h1;
        p_aux <= 1'b1;
        wt(6);
        chk({a_oe, a_sty}, 3'h5);
        @(posedge clk);
        adis <= 1'b0;
        ast <= 1'b1;
        wt(2);
        chk({a_oe, a_lvl}, 2'h1);
        @(posedge clk);
        ast <= 1'b0;
        wt(2);
        chk({a_oe, a_lvl}, 2'h0);
        $display("aux tests done");
        @(posedge clk);
        ldis <= 1'b0;
        aoc <= 1'b1;
        wt(8);
        @(posedge clk);
        aoc <= 1'b0;
        loc <= 1'b1;
        wt(12);
        chk({af, aff, lf}, 3'h0);
        for (n = 0; n < 30 && lf !== 1'b1; n++) wt(1);
        chk({lf, lff, irq_n, l_oe}, 4'hC);
        chk(n >= 8 && n <= 10, 1'b1);
        @(posedge clk);
        loc <= 1'b0;
        wt(8);
        chk({lf, lff, irq_n}, 3'h2);
        @(posedge clk);
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        wt(2);
        chk({lff, irq_n}, 2'h1);
        @(posedge clk);
        retry <= 1'b1;
        loc <= 1'b1;
        for (n = 0; n < 40 && lf !== 1'b1; n++) wt(1);
        wt(2);
        chk(l_oe, 1'b1);
        // Off time must match the fixed retry interval before re-enabling
        for (n = 0; n < 3000 && l_oe !== 1'b0; n++) wt(1);
        chk(n > 2500 && n < 2600, 1'b1);
        @(posedge clk);
        loc <= 1'b0;
        retry <= 1'b0;
        rstn <= 1'b0;
        wt(2);
        chk({l_oe, lff, irq_n}, 3'h5);
        @(posedge clk);
        rstn <= 1'b1;
        wt(6);
        $display("fault tests done");
        @(posedge clk);
        iss <= 1'b0;
        aoc <= 1'b1;
        wt(2000);
        chk(irq_n, 1'b1);
        for (n = 0; n < 800 && irq_n !== 1'b0; n++) wt(1);
        chk(n > 530 && n < 590, 1'b1);
        @(posedge clk);
        aoc <= 1'b0;
        wt(4);
        chk(irq_n, 1'b1);
        $display("pin fault test done");
        @(posedge clk);
        iss <= 1'b1;
        p_en <= 1'b0;
        p_tx <= 1'b1;
        lst <= 1'b0;
        wt(6);
        @(posedge clk);
        ups <= 1'b1;
        lvl_in <= 1'b1;
        wt(6);
        chk({spi, ush}, 2'h2);
        @(posedge clk);
        cspp <= 1'b1;
        wt(6);
        chk({spi, ush, so, so_oe}, 4'h4);
        @(posedge clk);
        rdis <= 1'b1;
        wt(4);
        chk({so_oe, rx_oe, llv}, 3'h6);
        @(posedge clk);
        rdis <= 1'b0;
        cspp <= 1'b0;
        mux <= 1'b1;
        p_clk <= 1'b1;
        sdi <= 1'b0;
        wt(6);
        chk({spi, ush}, 2'h1);
        @(posedge clk);
        ups <= 1'b0;
        wt(6);
        chk({l_oe, l_lvl}, 2'h1);
        @(posedge clk);
        p_clk <= 1'b0;
        sdi <= 1'b1;
        wt(6);
        chk({l_oe, l_lvl}, 2'h1);
        $display("mux tests done");
        @(posedge clk);
        mux <= 1'b0;
        trk <= 1'b1;
        sdi <= 1'b0;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        wt(1);
        while (busy) begin
            @(negedge lim);
            if (mid) begin
                chk({l_oe, l_lvl}, {1'b0, !txi});
                chk({a_oe, a_lvl}, {1'b0, !txi});
            end
            #1;
        end
        chk({spi, ush}, 2'h2);
        $display("frame test done");
        report_and_stop();
    end
endmodule
